// ==== rtl/nasd_elem_map.sv ====
// Splits a BACnet object number into element and base object
`timescale 1ns/10ps
module nasd_elem_map (
  // Request
  input  wire logic [nasd_pkg::OBJ_W-1:0]  obj_num,
  // Answer
  output logic      [nasd_pkg::ELEM_W-1:0] elem,
  output logic      [nasd_pkg::OBJ_W-1:0]  base_obj
);
  import nasd_pkg::*;

  logic [ELEM_N-1:0] above;

  // One threshold per element boundary
  genvar k;
  generate
    for (k = 1; k < ELEM_N; k++) begin : g_thr
      localparam logic [OBJ_W-1:0] THR = OBJ_W'(k * OBJ_STEP);
      assign above[k] = (obj_num >= THR);
    end
  endgenerate
  assign above[0] = 1'b0;

  always_comb begin
    elem = '0;
    for (int i = 1; i < ELEM_N; i++) begin
      if (above[i]) begin
        elem = ELEM_W'(i);
      end
    end
  end

  assign base_obj = obj_num - OBJ_W'(elem * OBJ_STEP);

endmodule : nasd_elem_map

// ==== rtl/nasd_pkg.sv ====
// Package of constants for the network address switch decoder
package nasd_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int DIG_W  = 4;
  localparam int VAL_W  = 10;
  localparam int ADDR_W = 8;
  localparam int OBJ_W  = 22;
  localparam int ELEM_W = 3;
  localparam int BAUD_W = 3;
  localparam int ELEM_N = 8;

  // ****************************************
  // Switch values
  // ****************************************
  localparam logic [VAL_W-1:0] SW_RESET     = 10'h000;
  localparam logic [VAL_W-1:0] SW_FIRST     = 10'h001;
  localparam logic [VAL_W-1:0] SW_BAC_MAX   = 10'h07f;
  localparam logic [VAL_W-1:0] SW_SLV_MIN   = 10'h080;
  localparam logic [VAL_W-1:0] SW_SLV_MAX   = 10'h0fe;
  localparam logic [VAL_W-1:0] SW_BCAST     = 10'h0ff;
  localparam logic [VAL_W-1:0] SW_MB_MAX    = 10'h0ef;
  localparam logic [VAL_W-1:0] SW_CONFIG    = 10'h3e7;
  localparam logic [DIG_W-1:0] DIG_MAX      = 4'h9;
  localparam logic [VAL_W-1:0] DIG_W100     = 10'h064;
  localparam logic [VAL_W-1:0] DIG_W10      = 10'h00a;

  // ****************************************
  // Configuration digits
  // ****************************************
  localparam logic [DIG_W-1:0] CFG_PROTO_BAC = 4'h2;
  localparam logic [DIG_W-1:0] CFG_BAUD_DEF  = 4'h0;

  // ****************************************
  // Baud codes and reset values
  // ****************************************
  localparam logic [BAUD_W-1:0] BAUD_9600   = 3'h0;
  localparam logic [BAUD_W-1:0] BAUD_19200  = 3'h1;
  localparam logic [BAUD_W-1:0] BAUD_38400  = 3'h2;
  localparam logic [BAUD_W-1:0] BAUD_57600  = 3'h3;
  localparam logic [BAUD_W-1:0] BAUD_76800  = 3'h4;
  localparam logic [BAUD_W-1:0] BAUD_115200 = 3'h5;
  localparam logic [BAUD_W-1:0] BAUD_MB_DEF  = BAUD_9600;
  localparam logic [BAUD_W-1:0] BAUD_BAC_DEF = BAUD_76800;
  localparam logic              PROTO_RST    = 1'b0;

  // ****************************************
  // Element mapping and network
  // ****************************************
  localparam logic [OBJ_W-1:0] OBJ_STEP  = 22'h004e20;
  localparam logic [31:0]      IP_STATIC = 32'hc0a8010a;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS     = 50;
  localparam int SETTLE_NS  = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W      = 6;

  // ****************************************
  // States
  // ****************************************
  typedef enum logic [2:0] {
    ST_SETTLE = 3'b001,
    ST_RUN    = 3'b010,
    ST_CFG    = 3'b100
  } nasd_state_t;

endpackage : nasd_pkg

// ==== rtl/nasd_sync.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module nasd_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign d_out = sync_q;

endmodule : nasd_sync

// ==== rtl/nasd_top.sv ====
// Rotary switch address decoder, mode select and element mapping
`timescale 1ns/10ps
module nasd_top (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // Rotary switch pins
  input  wire logic [nasd_pkg::DIG_W-1:0]   sw_hund,
  input  wire logic [nasd_pkg::DIG_W-1:0]   sw_tens,
  input  wire logic [nasd_pkg::DIG_W-1:0]   sw_ones,
  // Board pins
  input  wire logic                         eth_fitted,
  input  wire logic                         dhcp_cfg,
  input  wire logic                         cfg_commit,
  // Request from the link logic
  input  wire logic                         req_usb,
  input  wire logic [nasd_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [nasd_pkg::OBJ_W-1:0]   req_obj,
  // Mode and framing
  output logic                              cfg_mode_q,
  output logic                              proto_bac_q,
  output logic [nasd_pkg::BAUD_W-1:0]       baud_code_q,
  output logic                              serial_en_q,
  // Station address
  output logic [nasd_pkg::ADDR_W-1:0]       station_q,
  output logic                              station_ok_q,
  output logic                              slave_rsv_q,
  // Network
  output logic                              use_dhcp_q,
  output logic [31:0]                       ip_static_q,
  // Answer to the request
  output logic                              act_bac_q,
  output logic                              addr_hit_q,
  output logic                              bcast_hit_q,
  output logic [nasd_pkg::ELEM_W-1:0]       elem_q,
  output logic [nasd_pkg::OBJ_W-1:0]        base_obj_q
);
  import nasd_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [3*DIG_W-1:0] sw_s;
  logic [2:0]         pin_s;

  nasd_sync #(
    .W (3*DIG_W)
  ) u_sw_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d_in  ({sw_hund, sw_tens, sw_ones}),
    .d_out (sw_s)
  );

  nasd_sync #(
    .W (3)
  ) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d_in  ({eth_fitted, dhcp_cfg, cfg_commit}),
    .d_out (pin_s)
  );

  logic eth_s;
  logic dhcp_s;
  logic commit_s;

  assign eth_s    = pin_s[2];
  assign dhcp_s   = pin_s[1];
  assign commit_s = pin_s[0];

  // ****************************************
  // Decimal value of the switches
  // ****************************************
  logic [DIG_W-1:0] hund_c;
  logic [DIG_W-1:0] tens_c;
  logic [DIG_W-1:0] ones_c;
  logic [VAL_W-1:0] sw_val;

  // Non-decimal wheel codes read as nine
  assign hund_c = (sw_s[3*DIG_W-1:2*DIG_W] > DIG_MAX) ? DIG_MAX
                : sw_s[3*DIG_W-1:2*DIG_W];
  assign tens_c = (sw_s[2*DIG_W-1:DIG_W] > DIG_MAX) ? DIG_MAX
                : sw_s[2*DIG_W-1:DIG_W];
  assign ones_c = (sw_s[DIG_W-1:0] > DIG_MAX) ? DIG_MAX
                : sw_s[DIG_W-1:0];

  assign sw_val = {6'h00, hund_c} * DIG_W100
                + {6'h00, tens_c} * DIG_W10
                + {6'h00, ones_c};

  // ****************************************
  // Power-up state machine
  // ****************************************
  nasd_state_t      state_q;
  nasd_state_t      state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [VAL_W-1:0] base_q;
  logic [VAL_W-1:0] base_d;
  logic             settle_done;
  logic             commit_d1_q;
  logic             commit_edge;

  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);

  // Wait lets the synchronised wheels settle before the one sample
  assign settle_done = (state_q == ST_SETTLE) && (cnt_q == SETTLE_LAST);
  assign commit_edge = commit_s && !commit_d1_q;

  assign cnt_d = (state_q == ST_SETTLE) ? cnt_q + CNT_W'(1) : cnt_q;

  // Address read once; later turns have no effect until next reset, except tens and ones at a commit in config mode
  assign base_d = settle_done ? sw_val : base_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_SETTLE: begin
        if (settle_done) begin
          state_d = (sw_val == SW_CONFIG) ? ST_CFG : ST_RUN;
        end
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      ST_CFG: begin
        state_d = ST_CFG;
      end
      default: begin
        state_d = ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q     <= ST_SETTLE;
      cnt_q       <= '0;
      base_q      <= '0;
      commit_d1_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      base_q      <= base_d;
      commit_d1_q <= commit_s;
    end
  end

  // ****************************************
  // Protocol and baud rate
  // ****************************************
  logic              proto_d;
  logic [BAUD_W-1:0] baud_d;
  logic              cfg_proto;
  logic [BAUD_W-1:0] cfg_baud;
  logic              zero_sample;

  assign zero_sample = settle_done && (sw_val == SW_RESET);

  // Configuration: ones digit picks protocol, tens digit picks rate
  assign cfg_proto = (ones_c == CFG_PROTO_BAC);
  assign cfg_baud  = (tens_c == CFG_BAUD_DEF)
                   ? (cfg_proto ? BAUD_BAC_DEF : BAUD_MB_DEF)
                   : (tens_c > DIG_W'(BAUD_115200 + 3'h1)) ? BAUD_115200
                   : BAUD_W'(tens_c - 4'h1);

  assign proto_d = zero_sample ? 1'b0
                 : (state_q == ST_CFG && commit_edge) ? cfg_proto
                 : proto_bac_q;

  assign baud_d  = zero_sample ? BAUD_MB_DEF
                 : (state_q == ST_CFG && commit_edge) ? cfg_baud
                 : baud_code_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      proto_bac_q <= PROTO_RST;
      baud_code_q <= BAUD_MB_DEF;
      cfg_mode_q  <= 1'b0;
    end else begin
      proto_bac_q <= proto_d;
      baud_code_q <= baud_d;
      cfg_mode_q  <= (state_d == ST_CFG);
    end
  end

  // ****************************************
  // Station address decode
  // ****************************************
  logic ranged;
  logic bac_ok;
  logic mb_ok;
  logic slv_rsv;
  logic own_ok;

  assign ranged  = (state_q == ST_RUN);
  assign bac_ok  = (base_q >= SW_FIRST) && (base_q <= SW_BAC_MAX);
  assign slv_rsv = (base_q >= SW_SLV_MIN) && (base_q <= SW_SLV_MAX);
  assign mb_ok   = (base_q >= SW_FIRST) && (base_q <= SW_MB_MAX);
  // Zero and 255 never become the own station
  assign own_ok  = ranged && !eth_s && (proto_bac_q ? bac_ok : mb_ok);

  // ****************************************
  // Element lookup for one request
  // ****************************************
  logic [ELEM_W-1:0] obj_elem;
  logic [OBJ_W-1:0]  obj_base;
  logic [ADDR_W-1:0] base8;
  logic [ADDR_W:0]   mb_diff;
  logic              mb_hit;
  logic              bac_hit;
  logic              req_bac;
  logic              req_hit;
  logic              req_bcast;
  logic [ELEM_W-1:0] req_elem;

  nasd_elem_map u_elem_map (
    .obj_num  (req_obj),
    .elem     (obj_elem),
    .base_obj (obj_base)
  );

  assign base8   = base_q[ADDR_W-1:0];
  assign mb_diff = {1'b0, req_addr} - {1'b0, base8};
  // Element n at base plus n, A to H
  assign mb_hit  = !mb_diff[ADDR_W]
                 && (mb_diff[ADDR_W-1:0] < ADDR_W'(ELEM_N));
  assign bac_hit = (req_addr == base8);

  // USB bypasses the switches and always speaks Modbus
  assign req_bac   = req_usb ? 1'b0 : proto_bac_q;
  assign req_bcast = !req_usb && (req_addr == SW_BCAST[ADDR_W-1:0]);
  assign req_hit   = req_usb ? 1'b1
                   : !own_ok ? 1'b0
                   : (proto_bac_q ? bac_hit : mb_hit);
  assign req_elem  = req_bac ? obj_elem
                   : req_usb ? ELEM_W'(0)
                   : mb_diff[ELEM_W-1:0];

  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      station_q    <= '0;
      station_ok_q <= 1'b0;
      slave_rsv_q  <= 1'b0;
      serial_en_q  <= 1'b0;
      use_dhcp_q   <= 1'b0;
      ip_static_q  <= IP_STATIC;
      act_bac_q    <= 1'b0;
      addr_hit_q   <= 1'b0;
      bcast_hit_q  <= 1'b0;
      elem_q       <= '0;
      base_obj_q   <= '0;
    end else begin
      station_q    <= own_ok ? base8 : '0;
      station_ok_q <= own_ok;
      slave_rsv_q  <= ranged && proto_bac_q && slv_rsv;
      serial_en_q  <= !eth_s && (state_q != ST_SETTLE);
      use_dhcp_q   <= eth_s && dhcp_s;
      ip_static_q  <= IP_STATIC;
      act_bac_q    <= req_bac;
      addr_hit_q   <= req_hit;
      bcast_hit_q  <= req_bcast && ranged && !eth_s;
      elem_q       <= req_elem;
      base_obj_q   <= req_bac ? obj_base : req_obj;
    end
  end

endmodule : nasd_top

// ==== testbench/nasd_client.sv ====
// Client model that issues element requests to the decoder
`timescale 1ns/10ps
module nasd_client (
  // Clock
  input  wire logic                        clk,
  // Command from the bench
  input  wire logic                        c_usb,
  input  wire logic [nasd_pkg::ELEM_W-1:0] c_elem,
  input  wire logic [nasd_pkg::ADDR_W-1:0] c_base,
  input  wire logic [nasd_pkg::OBJ_W-1:0]  c_obj,
  // Request lines
  output logic                             req_usb,
  output logic [nasd_pkg::ADDR_W-1:0]      req_addr,
  output logic [nasd_pkg::OBJ_W-1:0]       req_obj
);
  import nasd_pkg::*;
  // Client reaches element n through address or object offsets
  always_ff @(posedge clk) begin
    req_usb  <= c_usb;
    req_addr <= c_base + ADDR_W'(c_elem);
    req_obj  <= c_obj + OBJ_W'(c_elem) * OBJ_STEP;
  end
endmodule : nasd_client

// ==== testbench/nasd_top_monitor.sv ====
// Concurrent checks on the decoder's ports
`timescale 1ns/10ps
module nasd_top_monitor (
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        rst_n,
  // Inputs
  input wire logic                        eth_fitted,
  input wire logic                        dhcp_cfg,
  input wire logic                        req_usb,
  input wire logic [nasd_pkg::ADDR_W-1:0] req_addr,
  input wire logic [nasd_pkg::OBJ_W-1:0]  req_obj,
  // Outputs
  input wire logic                        cfg_mode_q,
  input wire logic                        proto_bac_q,
  input wire logic [nasd_pkg::BAUD_W-1:0] baud_code_q,
  input wire logic                        serial_en_q,
  input wire logic [nasd_pkg::ADDR_W-1:0] station_q,
  input wire logic                        station_ok_q,
  input wire logic                        use_dhcp_q,
  input wire logic [31:0]                 ip_static_q,
  input wire logic                        act_bac_q,
  input wire logic                        addr_hit_q,
  input wire logic                        bcast_hit_q,
  input wire logic [nasd_pkg::ELEM_W-1:0] elem_q,
  input wire logic [nasd_pkg::OBJ_W-1:0]  base_obj_q
);
  import nasd_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ********
  // Assertions
  // ********
  a_ip_fixed: assert property (ip_static_q == IP_STATIC)
    else $error("static address wrong");
  a_dhcp_cfg_only: assert property (use_dhcp_q |-> $past(dhcp_cfg, 3))
    else $error("dhcp without config");
  a_eth_serial_off: assert property (eth_fitted[*4] |=> !serial_en_q)
    else $error("serial port on with ethernet");
  a_eth_no_hit: assert property ((eth_fitted[*4] ##0 !req_usb) |=> !addr_hit_q)
    else $error("switch address used over ethernet");
  a_usb_modbus: assert property (req_usb |=> addr_hit_q && !act_bac_q)
    else $error("usb request not modbus hit");
  a_station_range: assert property (station_ok_q |-> station_q != 8'h00 && station_q <= 8'hef)
    else $error("station outside range");
  a_bac_station: assert property (station_ok_q && proto_bac_q |-> station_q <= 8'h7f)
    else $error("bacnet station above range");
  // Unsigned difference wraps, so a request below base never qualifies
  a_mb_element: assert property ((!req_usb && !eth_fitted && station_ok_q && !proto_bac_q
    && (req_addr - station_q) < 8'h08) |=> addr_hit_q
    && elem_q == $past(req_addr - station_q))
    else $error("modbus element wrong");
  a_obj_split: assert property ((proto_bac_q && !req_usb && req_obj < 22'h027100) |=>
    base_obj_q + 22'(elem_q) * OBJ_STEP == $past(req_obj))
    else $error("object split wrong");
  a_cfg_hold: assert property (!cfg_mode_q |=> $stable(proto_bac_q) && $stable(baud_code_q))
    else $error("protocol changed outside config");
  a_bcast_not_own: assert property (bcast_hit_q |-> !addr_hit_q)
    else $error("broadcast taken as own address");
  c_usb_req: cover property (req_usb ##1 addr_hit_q);
  c_bac_on: cover property (proto_bac_q);
  c_bcast: cover property (bcast_hit_q);
endmodule : nasd_top_monitor

bind nasd_top nasd_top_monitor mon_u (.*);

// ==== testbench/testbench.sv ====
// Self-checking bench for the rotary switch address decoder
`timescale 1ns/10ps
module testbench;
  import nasd_pkg::*;
  typedef struct {logic [3:0] h, t, o; logic [7:0] st; logic ok;} nasd_row_t;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  logic [DIG_W-1:0]    sw_hund = 4'h0, sw_tens = 4'h0, sw_ones = 4'h1;
  logic                eth_fitted = 1'b0, dhcp_cfg = 1'b0, cfg_commit = 1'b0;
  logic                c_usb = 1'b0, req_usb, cfg_mode_q, proto_bac_q, serial_en_q;
  logic                station_ok_q, slave_rsv_q, use_dhcp_q, act_bac_q;
  logic                addr_hit_q, bcast_hit_q;
  logic [ELEM_W-1:0]   c_elem = 3'h0, elem_q;
  logic [ADDR_W-1:0]   c_base = 8'h01, station_q, req_addr;
  logic [OBJ_W-1:0]    c_obj = 22'h000000, req_obj, base_obj_q;
  logic [BAUD_W-1:0]   baud_code_q;
  logic [31:0]         ip_static_q;
  int                  errors = 0, checks = 0, cyc = 0;
  nasd_row_t           rows [6] = '{'{4'h0, 4'h0, 4'h0, 8'h00, 1'b0},
    '{4'h0, 4'h0, 4'h1, 8'h01, 1'b1}, '{4'h1, 4'h2, 4'h8, 8'h80, 1'b1},
    '{4'h2, 4'h3, 4'h9, 8'hef, 1'b1}, '{4'h2, 4'h4, 4'h0, 8'h00, 1'b0},
    '{4'h2, 4'h5, 4'h5, 8'h00, 1'b0}};

  nasd_top dut_u (.*);
  nasd_client cli_u (.*);

  always #25 clk = ~clk;
  // Whole run is well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      test_done;
    end
  end

  // ********
  // Tasks
  // ********
  task automatic chk(input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // The address is read once after reset, so each address setting needs a reboot
  task automatic boot(input logic [3:0] a, b, c, input logic e, d);
    @(posedge clk);
    rst_n <= 1'b0;
    sw_hund <= a;
    sw_tens <= b;
    sw_ones <= c;
    eth_fitted <= e;
    dhcp_cfg <= d;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (23) @(posedge clk);
    #1;
  endtask : boot

  task automatic rq(input logic u, input logic [2:0] e, input logic [7:0] b,
                    input logic [21:0] ob);
    @(posedge clk);
    c_usb <= u;
    c_elem <= e;
    c_base <= b;
    c_obj <= ob;
    repeat (2) @(posedge clk);
    #1;
  endtask : rq

  task automatic cfg(input logic [3:0] tt, oo);
    @(posedge clk);
    sw_tens <= tt;
    sw_ones <= oo;
    repeat (3) @(posedge clk);
    cfg_commit <= 1'b1;
    @(posedge clk);
    cfg_commit <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : cfg

  task automatic test_done;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  // ********
  // Sequence
  // ********
  initial begin
    foreach (rows[i]) begin
      boot(rows[i].h, rows[i].t, rows[i].o, 1'b0, 1'b0);
      chk(station_ok_q, rows[i].ok);
      chk(station_q, rows[i].st);
      chk(proto_bac_q, 1'b0);
      chk(slave_rsv_q, 1'b0);
      chk(baud_code_q, BAUD_9600);
      if (rows[i].ok) begin
        rq(1'b0, 3'h7, rows[i].st, 22'h000000);
        chk(addr_hit_q, 1'b1);
        chk(elem_q, 3'h7);
        rq(1'b0, 3'h0, 8'hff, 22'h000000);
        chk(bcast_hit_q, 1'b1);
        chk(addr_hit_q, 1'b0);
      end
    end
    boot(4'h0, 4'h0, 4'h1, 1'b0, 1'b1);
    chk(use_dhcp_q, 1'b0);
    chk(serial_en_q, 1'b1);
    chk(ip_static_q, IP_STATIC);
    rq(1'b0, 3'h0, 8'h09, 22'h000000);
    chk(addr_hit_q, 1'b0);
    rq(1'b1, 3'h0, 8'h55, 22'h000000);
    chk(addr_hit_q, 1'b1);
    chk(act_bac_q, 1'b0);
    cfg(4'h0, 4'h2);
    chk(proto_bac_q, 1'b0);
    boot(4'h0, 4'h0, 4'h1, 1'b1, 1'b1);
    chk(serial_en_q, 1'b0);
    chk(use_dhcp_q, 1'b1);
    rq(1'b0, 3'h0, 8'h01, 22'h000000);
    chk(addr_hit_q, 1'b0);
    boot(4'h9, 4'h9, 4'h9, 1'b0, 1'b0);
    chk(cfg_mode_q, 1'b1);
    chk(station_ok_q, 1'b0);
    for (int k = 0; k < 8; k++) begin
      cfg(4'(k), 4'h1);
      chk(baud_code_q, k == 0 ? 3'h0 : k > 6 ? 3'h5 : 3'(k - 1));
      chk(proto_bac_q, 1'b0);
    end
    cfg(4'h0, 4'h2);
    chk(proto_bac_q, 1'b1);
    chk(baud_code_q, BAUD_76800);
    rq(1'b0, 3'h4, 8'h01, 22'h003aa2);
    chk(act_bac_q, 1'b1);
    chk(elem_q, 3'h4);
    chk(base_obj_q, 22'h003aa2);
    test_done;
  end
endmodule : testbench
